// file: hw/cdmb_bit_unit.sv
`timescale 1ns/100ps
`default_nettype none
`include "cdmb_regs.svh"

module cdmb_bit_unit
  import cdmb_pkg::*;
(
  input wire cdmb_op_e op,
  input wire logic [7:0] val,
  input wire logic [7:0] flags_in,
  input wire logic [2:0] bitn,
  output logic [7:0] res,
  output logic res_we,
  output logic [7:0] flags_out
);

  logic [7:0] mask;
  logic cy;
  logic ng;
  logic ov;

  assign mask = 8'(8'h01 << bitn);

  // Single-cycle register and flag operations
  always_comb begin
    res = val;
    res_we = 1'b0;
    flags_out = flags_in;
    cy = flags_in[`CDMB_FLG_C];
    case (op)
      op_rotate_left_carry, op_rotate_right_carry: begin
        if (op == op_rotate_left_carry) begin
          res = {val[6:0], flags_in[`CDMB_FLG_C]};
          cy = val[7];
        end else begin
          res = {flags_in[`CDMB_FLG_C], val[7:1]};
          cy = val[0];
        end
        res_we = 1'b1;
      end
      op_copy_bit_to_flag: flags_out[`CDMB_FLG_T] = val[bitn];
      op_copy_flag_to_bit: begin
        res = flags_in[`CDMB_FLG_T] ? (val | mask) : (val & ~mask);
        res_we = 1'b1;
      end
      op_sign_flag_on: flags_out[`CDMB_FLG_S] = 1'b1;
      op_sign_flag_off: flags_out[`CDMB_FLG_S] = 1'b0;
      op_overflow_flag_on: flags_out[`CDMB_FLG_V] = 1'b1;
      op_overflow_flag_off: flags_out[`CDMB_FLG_V] = 1'b0;
      op_half_carry_off: flags_out[`CDMB_FLG_H] = 1'b0;
      default: res_we = 1'b0;
    endcase
    ng = res[7];
    ov = ng ^ cy;
    // Rotates refresh Z, C, N, V and the derived sign
    if (op == op_rotate_left_carry || op == op_rotate_right_carry) begin
      flags_out[`CDMB_FLG_Z] = (res == 8'h00);
      flags_out[`CDMB_FLG_C] = cy;
      flags_out[`CDMB_FLG_N] = ng;
      flags_out[`CDMB_FLG_V] = ov;
      flags_out[`CDMB_FLG_S] = ng ^ ov;
    end
  end

endmodule

`default_nettype wire

// file: hw/cdmb_core.sv
// Our own choices: the address map and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "cdmb_regs.svh"

module cdmb_core
  import cdmb_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [15:0] dmem_addr,
  output logic dmem_re,
  output logic dmem_we,
  output logic [7:0] dmem_wdata,
  input wire logic [7:0] dmem_rdata,
  output logic [4:0] io_addr,
  output logic io_re,
  output logic io_we,
  output logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  output logic [15:0] pmem_addr,
  output logic pmem_re,
  input wire logic [7:0] pmem_rdata,
  output logic busy
);

  // Pointer pair low index from selector
  function automatic logic [4:0] ptr_base(input logic [1:0] sel);
    if (sel == 2'h0) begin
      return `CDMB_PTR_X_LO;
    end else if (sel == 2'h1) begin
      return `CDMB_PTR_Y_LO;
    end
    return `CDMB_PTR_Z_LO;
  endfunction

  // Sixteen-bit step with wrap, for pointers and stack
  function automatic logic [15:0] step16(input logic [15:0] v, input logic up);
    return up ? 16'(v + 16'h0001) : 16'(v - 16'h0001);
  endfunction

  logic [1:0] rst_sync_q;
  logic rst_n;
  cdmb_state_e state_q, state_d;
  logic [`CDMB_CMD_W-1:0] cmd_q;
  logic [15:0] opnd_q;
  logic [7:0] flags_q;
  logic [15:0] pc_q;
  logic [15:0] sp_q;
  logic [4:0] ridx_q;
  logic [7:0] rf_q [0:31];
  logic pready_q, pslverr_q, busy_q;
  logic [31:0] prdata_q;
  logic [15:0] dmem_addr_q, pmem_addr_q;
  logic dmem_re_q, dmem_we_q, io_re_q, io_we_q, pmem_re_q;
  logic [7:0] dmem_wdata_q, io_wdata_q;
  logic [4:0] io_addr_q;

  // Reset release through two flip-flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // APB address decode and transfer phases
  wire apb_acc = psel & penable & ~pready_q;
  wire apb_fire = psel & penable & pready_q;
  wire hit_cmd = (paddr == `CDMB_CMD_OFS);
  wire hit_opnd = (paddr == `CDMB_OPND_OFS);
  wire hit_stat = (paddr == `CDMB_STAT_OFS);
  wire hit_flags = (paddr == `CDMB_FLAGS_OFS);
  wire hit_pc = (paddr == `CDMB_PC_OFS);
  wire hit_sp = (paddr == `CDMB_SP_OFS);
  wire hit_ridx = (paddr == `CDMB_RIDX_OFS);
  wire hit_rdata = (paddr == `CDMB_RDATA_OFS);
  wire addr_ok = hit_cmd | hit_opnd | hit_stat | hit_flags | hit_pc | hit_sp | hit_ridx
                 | hit_rdata;
  wire is_busy = (state_q != st_idle);
  wire bad_wr = pwrite & is_busy & ~hit_stat;
  wire apb_err = ~addr_ok | bad_wr;
  wire wr_ok = apb_fire & pwrite & addr_ok & ~is_busy;
  wire cmd_go = wr_ok & hit_cmd;

  // Read data selection
  logic [31:0] rd_mux;
  assign rd_mux = hit_cmd ? {15'h0000, cmd_q}
                : hit_opnd ? {16'h0000, opnd_q}
                : hit_stat ? {29'h0000_0000, state_q, is_busy}
                : hit_flags ? {24'h00_0000, flags_q}
                : hit_pc ? {16'h0000, pc_q}
                : hit_sp ? {16'h0000, sp_q}
                : hit_ridx ? {27'h000_0000, ridx_q}
                : hit_rdata ? {24'h00_0000, rf_q[ridx_q]}
                : 32'h0000_0000;

  // APB answer one cycle into the access phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= apb_acc;
      pslverr_q <= apb_acc & apb_err;
      prdata_q <= (apb_acc & ~pwrite & addr_ok) ? rd_mux : 32'h0000_0000;
    end
  end

  // Command fields
  cdmb_op_e op;
  cdmb_ptr_mode_e pmode;
  logic [4:0] reg_idx;
  logic [2:0] bitn;
  logic [1:0] ptr_sel;
  assign op = cdmb_op_e'(cmd_q[`CDMB_F_OP_MSB:`CDMB_F_OP_LSB]);
  assign pmode = cdmb_ptr_mode_e'(cmd_q[`CDMB_F_MODE_MSB:`CDMB_F_MODE_LSB]);
  assign reg_idx = cmd_q[`CDMB_F_REG_MSB:`CDMB_F_REG_LSB];
  assign bitn = cmd_q[`CDMB_F_BIT_MSB:`CDMB_F_BIT_LSB];
  assign ptr_sel = cmd_q[`CDMB_F_PTR_MSB:`CDMB_F_PTR_LSB];

  // Instruction class decode
  wire is_br_on = (op == op_branch_on_irq_on);
  wire is_br_off = (op == op_branch_on_irq_off);
  wire is_ld_ptr = (op == op_load_via_pointer);
  wire is_st_ptr = (op == op_write_via_pointer);
  wire is_ofs = (op == op_load_with_offset) | (op == op_write_with_offset);
  wire is_abs = (op == op_load_absolute) | (op == op_write_absolute);
  wire is_lpm = (op == op_load_program_byte);
  wire is_push = (op == op_push);
  wire is_pop = (op == op_pop);
  wire is_set = (op == op_io_bit_set);
  wire is_io = is_set | (op == op_io_bit_clear);
  wire is_dload = is_ld_ptr | (op == op_load_with_offset) | (op == op_load_absolute)
                  | is_pop;
  wire is_dstore = is_st_ptr | (op == op_write_with_offset) | (op == op_write_absolute)
                   | is_push;
  wire in_exec = (state_q == st_exec);
  wire in_wait = (state_q == st_wait);

  // Branch condition on the global interrupt enable flag
  wire br_taken = (is_br_on & flags_q[`CDMB_FLG_I])
                  | (is_br_off & ~flags_q[`CDMB_FLG_I]);
  wire needs_wait = is_dload | is_dstore | is_io | is_lpm | br_taken;

  // Program counter advance
  wire [15:0] br_ofs = {{9{opnd_q[6]}}, opnd_q[6:0]};
  wire [15:0] pc_step = br_taken ? 16'(br_ofs + 16'h0001)
                      : (is_abs ? 16'h0002 : 16'h0001);
  wire [15:0] pc_next = 16'(pc_q + pc_step);

  // Pointer selection: offset forms use Y or Z, program loads use Z
  wire [1:0] ptr_pick = is_lpm ? 2'h2
                      : (is_ofs & (ptr_sel == 2'h0)) ? 2'h1 : ptr_sel;
  wire [4:0] ptr_lo = ptr_base(ptr_pick);
  wire [4:0] ptr_hi = {ptr_lo[4:1], 1'b1};
  wire [15:0] ptr_val = {rf_q[ptr_hi], rf_q[ptr_lo]};
  wire is_pre = (pmode == pm_pre_dec) & (is_ld_ptr | is_st_ptr);
  wire is_post = (pmode == pm_post_inc) & (is_ld_ptr | is_st_ptr | is_lpm);
  wire [15:0] ptr_new = step16(ptr_val, ~is_pre);

  // Data address for the access
  wire [15:0] sp_up = step16(sp_q, 1'b1);
  wire [15:0] sp_down = step16(sp_q, 1'b0);
  wire [15:0] d_addr = is_abs ? opnd_q
                     : is_ofs ? 16'(ptr_val + {10'h000, opnd_q[5:0]})
                     : is_pre ? ptr_new
                     : is_push ? sp_q
                     : is_pop ? sp_up
                     : ptr_val;

  // Register and flag operations
  logic [7:0] bu_res;
  logic bu_we;
  logic [7:0] bu_flags;
  cdmb_bit_unit u_bit_unit (
    .op(op),
    .val(rf_q[reg_idx]),
    .flags_in(flags_q),
    .bitn(bitn),
    .res(bu_res),
    .res_we(bu_we),
    .flags_out(bu_flags)
  );

  // Register file write sources
  wire host_rf_we = wr_ok & hit_rdata;
  wire ptr_we = in_exec & (is_pre | is_post) & ~is_ofs;
  wire bit_we = in_exec & bu_we;
  wire cap_we = (in_wait & is_dload) | ((state_q == st_wait2) & is_lpm);
  wire [4:0] cap_idx = (is_lpm & (pmode == pm_r0_form)) ? `CDMB_R0 : reg_idx;
  wire [7:0] cap_data = is_lpm ? pmem_rdata : dmem_rdata;
  wire [7:0] io_mask = 8'(8'h01 << bitn);

  // State sequencing: one cycle per instruction cycle
  always_comb begin
    state_d = state_q;
    case (state_q)
      st_idle: state_d = cmd_go ? st_exec : st_idle;
      st_exec: state_d = needs_wait ? st_wait : st_idle;
      st_wait: state_d = is_lpm ? st_wait2 : st_idle;
      st_wait2: state_d = st_idle;
      default: state_d = st_idle;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= st_idle;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      busy_q <= (state_d != st_idle);
    end
  end

  // Software-written command, operand and index
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_q <= 17'h0_0000;
      opnd_q <= 16'h0000;
      ridx_q <= 5'h00;
    end else begin
      if (cmd_go) cmd_q <= pwdata[`CDMB_CMD_W-1:0];
      if (wr_ok & hit_opnd) opnd_q <= pwdata[15:0];
      if (wr_ok & hit_ridx) ridx_q <= pwdata[4:0];
    end
  end

  // Flags, program counter and stack pointer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= `CDMB_FLAGS_RST;
      pc_q <= `CDMB_PC_RST;
      sp_q <= `CDMB_SP_RST;
    end else if (in_exec) begin
      flags_q <= bu_flags;
      pc_q <= pc_next;
      if (is_push) sp_q <= sp_down;
      if (is_pop) sp_q <= sp_up;
    end else begin
      if (wr_ok & hit_flags) flags_q <= pwdata[7:0];
      if (wr_ok & hit_pc) pc_q <= pwdata[15:0];
      if (wr_ok & hit_sp) sp_q <= pwdata[15:0];
    end
  end

  // Register file; loads land after the pointer step
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 32; i++) begin
        rf_q[i] <= 8'h00;
      end
    end else begin
      if (host_rf_we) rf_q[ridx_q] <= pwdata[7:0];
      if (ptr_we) begin
        rf_q[ptr_lo] <= ptr_new[7:0];
        rf_q[ptr_hi] <= ptr_new[15:8];
      end
      if (bit_we) rf_q[reg_idx] <= bu_res;
      if (cap_we) rf_q[cap_idx] <= cap_data;
    end
  end

  // Data memory strobes, issued from the execute cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dmem_re_q <= 1'b0;
      dmem_we_q <= 1'b0;
      dmem_addr_q <= 16'h0000;
      dmem_wdata_q <= 8'h00;
    end else begin
      dmem_re_q <= in_exec & is_dload;
      dmem_we_q <= in_exec & is_dstore;
      if (in_exec & (is_dload | is_dstore)) begin
        dmem_addr_q <= d_addr;
        dmem_wdata_q <= rf_q[reg_idx];
      end
    end
  end

  // I/O read-modify-write and program memory read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      io_re_q <= 1'b0;
      io_we_q <= 1'b0;
      io_addr_q <= 5'h00;
      io_wdata_q <= 8'h00;
      pmem_re_q <= 1'b0;
      pmem_addr_q <= 16'h0000;
    end else begin
      io_re_q <= in_exec & is_io;
      io_we_q <= in_wait & is_io;
      if (in_exec & is_io) io_addr_q <= opnd_q[4:0];
      if (in_wait & is_io) begin
        io_wdata_q <= is_set ? (io_rdata | io_mask)
                    : (io_rdata & ~io_mask);
      end
      pmem_re_q <= in_exec & is_lpm;
      if (in_exec & is_lpm) pmem_addr_q <= ptr_val;
    end
  end

  // Outputs straight from flip-flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign dmem_addr = dmem_addr_q;
  assign dmem_re = dmem_re_q;
  assign dmem_we = dmem_we_q;
  assign dmem_wdata = dmem_wdata_q;
  assign io_addr = io_addr_q;
  assign io_re = io_re_q;
  assign io_we = io_we_q;
  assign io_wdata = io_wdata_q;
  assign pmem_addr = pmem_addr_q;
  assign pmem_re = pmem_re_q;
  assign busy = busy_q;

endmodule

`default_nettype wire

// file: hw/cdmb_pkg.sv
`default_nettype none
package cdmb_pkg;

  typedef enum logic [4:0] {
    op_nop,
    op_branch_on_irq_on,
    op_branch_on_irq_off,
    op_load_via_pointer,
    op_load_with_offset,
    op_write_via_pointer,
    op_write_with_offset,
    op_load_absolute,
    op_write_absolute,
    op_load_program_byte,
    op_push,
    op_pop,
    op_io_bit_set,
    op_io_bit_clear,
    op_rotate_left_carry,
    op_rotate_right_carry,
    op_copy_bit_to_flag,
    op_copy_flag_to_bit,
    op_sign_flag_on,
    op_sign_flag_off,
    op_overflow_flag_on,
    op_overflow_flag_off,
    op_half_carry_off
  } cdmb_op_e;

  typedef enum logic [1:0] {
    st_idle,
    st_exec,
    st_wait,
    st_wait2
  } cdmb_state_e;

  typedef enum logic [1:0] {
    pm_plain,
    pm_post_inc,
    pm_pre_dec,
    pm_r0_form
  } cdmb_ptr_mode_e;

endpackage

`default_nettype wire

// file: hw/cdmb_regs.svh
`ifndef CDMB_REGS_SVH
`define CDMB_REGS_SVH

// Register offsets on the APB side (byte addresses)
`define CDMB_CMD_OFS 8'h00
`define CDMB_OPND_OFS 8'h04
`define CDMB_STAT_OFS 8'h08
`define CDMB_FLAGS_OFS 8'h0C
`define CDMB_PC_OFS 8'h10
`define CDMB_SP_OFS 8'h14
`define CDMB_RIDX_OFS 8'h18
`define CDMB_RDATA_OFS 8'h1C

// Command word fields
`define CDMB_F_OP_MSB 4
`define CDMB_F_OP_LSB 0
`define CDMB_F_REG_MSB 9
`define CDMB_F_REG_LSB 5
`define CDMB_F_BIT_MSB 12
`define CDMB_F_BIT_LSB 10
`define CDMB_F_MODE_MSB 14
`define CDMB_F_MODE_LSB 13
`define CDMB_F_PTR_MSB 16
`define CDMB_F_PTR_LSB 15
`define CDMB_CMD_W 17

// Status flag positions
`define CDMB_FLG_I 7
`define CDMB_FLG_T 6
`define CDMB_FLG_H 5
`define CDMB_FLG_S 4
`define CDMB_FLG_V 3
`define CDMB_FLG_N 2
`define CDMB_FLG_Z 1
`define CDMB_FLG_C 0

// Register file indices of the pointer pairs and register zero
`define CDMB_R0 5'h00
`define CDMB_PTR_X_LO 5'h1A
`define CDMB_PTR_Y_LO 5'h1C
`define CDMB_PTR_Z_LO 5'h1E

// Reset values
`define CDMB_SP_RST 16'h10FF
`define CDMB_PC_RST 16'h0000
`define CDMB_FLAGS_RST 8'h00

`endif

// file: verif/cdmb_core_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module cdmb_core_monitor (
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic dmem_re,
  input wire logic dmem_we,
  input wire logic io_re,
  input wire logic io_we,
  input wire logic pmem_re,
  input wire logic busy
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // Bus answer timing and refusals
  apb_one_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered after one wait");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  idle_rdata_a: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside answer");
  unmapped_err_a: assert property (pready && paddr > 8'h1C |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  // Execution start and length
  busy_start_a: assert property ($rose(busy) |-> $past(pready && pwrite && paddr == 8'h00 && !pslverr))
    else $error("busy without accepted command");
  busy_bound_a: assert property (busy [*3] |=> !busy)
    else $error("instruction longer than three cycles");
  dmem_two_a: assert property (dmem_re || dmem_we |-> busy && $past(busy) ##1 !busy)
    else $error("data access not in second of two cycles");
  strobe_excl_a: assert property (dmem_re |-> !dmem_we ##1 !dmem_re)
    else $error("data strobes overlap");
  pmem_three_a: assert property (pmem_re |-> busy && $past(busy) ##1 busy ##1 !busy)
    else $error("program read not in three cycles");
  io_rmw_a: assert property (io_re |-> busy ##1 (io_we && !busy))
    else $error("io write not after io read");
endmodule

bind cdmb_core cdmb_core_monitor i_mon (.clk(clk), .nrst(nrst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .dmem_re(dmem_re), .dmem_we(dmem_we), .io_re(io_re), .io_we(io_we),
  .pmem_re(pmem_re), .busy(busy));
`default_nettype wire

// file: verif/cdmb_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module cdmb_mem_model (
  input wire logic clk,
  input wire logic [15:0] dmem_addr,
  input wire logic dmem_re,
  input wire logic dmem_we,
  input wire logic [7:0] dmem_wdata,
  output logic [7:0] dmem_rdata,
  input wire logic [4:0] io_addr,
  input wire logic io_re,
  input wire logic io_we,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  input wire logic [15:0] pmem_addr,
  input wire logic pmem_re,
  output logic [7:0] pmem_rdata
);
  logic [7:0] ram [65536];
  logic [7:0] io_q [32];
  logic [7:0] pd_q;
  logic pv_q = 1'b0;
  // Known contents so no read returns unknown
  initial begin
    for (int i = 0; i < 65536; i++) begin
      ram[i] = 8'(i * 5);
    end
    for (int i = 0; i < 32; i++) begin
      io_q[i] = 8'(i * 37);
    end
  end
  // Writes at the strobe edge; program memory answers a cycle late
  always @(posedge clk) begin
    if (dmem_we) begin
      ram[dmem_addr] <= dmem_wdata;
    end
    if (io_we) begin
      io_q[io_addr] <= io_wdata;
    end
    pv_q <= pmem_re;
    pd_q <= pmem_addr[7:0] ^ pmem_addr[15:8] ^ 8'hA5;
  end
  // Unstrobed read lines show inverted data
  assign dmem_rdata = dmem_re ? ram[dmem_addr] : ~ram[dmem_addr];
  assign io_rdata = io_re ? io_q[io_addr] : ~io_q[io_addr];
  assign pmem_rdata = pv_q ? pd_q : ~pd_q;
endmodule
`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "cdmb_regs.svh"
module tb_top;
  import cdmb_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, r;
  logic pready, pslverr, busy, dmem_re, dmem_we, io_re, io_we, pmem_re, e, tk;
  logic [15:0] dmem_addr, pmem_addr, pa, ea, na, ga;
  logic [7:0] dmem_wdata, dmem_rdata, io_wdata, io_rdata, pmem_rdata, v, f, w;
  logic [4:0] io_addr, d, op;
  logic [2:0] b;
  logic [1:0] m, p;
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;
  // Clock
  initial begin
    forever #10 clk = ~clk;
  end
  cdmb_core i_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dmem_addr(dmem_addr), .dmem_re(dmem_re), .dmem_we(dmem_we), .dmem_wdata(dmem_wdata),
    .dmem_rdata(dmem_rdata), .io_addr(io_addr), .io_re(io_re), .io_we(io_we),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .pmem_addr(pmem_addr), .pmem_re(pmem_re),
    .pmem_rdata(pmem_rdata), .busy(busy));
  cdmb_mem_model i_mem (.clk(clk), .dmem_addr(dmem_addr), .dmem_re(dmem_re),
    .dmem_we(dmem_we), .dmem_wdata(dmem_wdata), .dmem_rdata(dmem_rdata), .io_addr(io_addr),
    .io_re(io_re), .io_we(io_we), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .pmem_addr(pmem_addr), .pmem_re(pmem_re), .pmem_rdata(pmem_rdata));
  task automatic print_verdict;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One bus transfer, held until ready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic setr(input logic [4:0] i, input logic [7:0] val);
    apb(1'b1, `CDMB_RIDX_OFS, {27'h0, i});
    apb(1'b1, `CDMB_RDATA_OFS, {24'h0, val});
  endtask
  task automatic getr(input logic [4:0] i);
    apb(1'b1, `CDMB_RIDX_OFS, {27'h0, i});
    apb(1'b0, `CDMB_RDATA_OFS, 32'h0);
  endtask
  task automatic setp(input logic [1:0] pp, input logic [15:0] val);
    setr(5'd26 + {pp, 1'b0}, val[7:0]);
    setr(5'd27 + {pp, 1'b0}, val[15:8]);
  endtask
  task automatic getp(input logic [1:0] pp, output logic [15:0] o);
    getr(5'd26 + {pp, 1'b0});
    o[7:0] = r[7:0];
    getr(5'd27 + {pp, 1'b0});
    o[15:8] = r[7:0];
  endtask
  // Issue a command and count its busy cycles
  task automatic exec(input logic [16:0] c, input logic [15:0] o, input int cy);
    apb(1'b1, `CDMB_OPND_OFS, {16'h0, o});
    apb(1'b1, `CDMB_CMD_OFS, {15'h0, c});
    n = 0;
    @(posedge clk);
    while (busy === 1'b1) begin
      n++;
      @(posedge clk);
    end
    chk(n, cy);
  endtask
  function automatic logic [16:0] cmd(input logic [4:0] o, input logic [4:0] rg,
      input logic [2:0] bt, input logic [1:0] md, input logic [1:0] pt);
    return {pt, md, bt, rg, o};
  endfunction
  // Expected register and flags after a bit or flag operation
  function automatic logic [15:0] bitop(input logic [4:0] o, input logic [7:0] x,
      input logic [7:0] fl, input logic [2:0] bt);
    logic [7:0] res;
    logic c;
    res = (o == 5'h0E) ? {x[6:0], fl[0]} : (o == 5'h0F) ? {fl[0], x[7:1]} : x;
    c = (o == 5'h0E) ? x[7] : x[0];
    if (o < 5'h10) fl[4:0] = {c, res[7] ^ c, res[7], res == 8'h00, c};
    if (o == 5'h10) fl[6] = x[bt];
    if (o == 5'h11) res[bt] = fl[6];
    if (o == 5'h12 || o == 5'h13) fl[4] = (o == 5'h12);
    if (o == 5'h14 || o == 5'h15) fl[3] = (o == 5'h14);
    if (o == 5'h16) fl[5] = 1'b0;
    return {res, fl};
  endfunction
  // Main sequence
  initial begin
    void'($urandom(32'h662e_4ac7));
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    apb(1'b0, `CDMB_SP_OFS, 32'h0);
    chk(r, 32'h0000_10FF);
    apb(1'b0, `CDMB_FLAGS_OFS, 32'h0);
    chk(r, 32'h0000_0000);
    apb(1'b0, 8'h20, 32'h0);
    chk({e, r[30:0]}, 32'h8000_0000);
    for (int i = 0; i < 8; i++) begin
      w = i[2] ? 8'($urandom) : {1'b0, i[0], {6{~i[0]}}};
      tk = i[1] ^ i[0];
      apb(1'b1, `CDMB_FLAGS_OFS, {24'h0, i[0], 7'($urandom)});
      apb(1'b1, `CDMB_PC_OFS, 32'h0000_0100);
      exec(cmd(5'h01 + 5'(i[1]), 5'h0, 3'h0, 2'h0, 2'h0), {8'h0, w}, tk ? 2 : 1);
      apb(1'b0, `CDMB_PC_OFS, 32'h0);
      chk(r, tk ? 32'h0000_0101 + {{25{w[6]}}, w[6:0]} : 32'h0000_0101);
    end
    for (int i = 0; i < 9; i++) begin
      p = 2'(i / 3);
      m = 2'(i % 3);
      pa = (i == 1) ? 16'hFFFF : (i == 2) ? 16'h0000 : 16'($urandom);
      d = 5'($urandom_range(1, 25));
      v = 8'($urandom);
      ea = (m == 2'h2) ? pa - 16'h0001 : pa;
      na = (m == 2'h1) ? pa + 16'h0001 : ea;
      setr(d, v);
      setp(p, pa);
      exec(cmd(5'h05, d, 3'h0, m, p), 16'h0, 2);
      getp(p, ga);
      chk(32'(ga), 32'(na));
      exec(cmd(5'h07, 5'h0, 3'h0, 2'h0, 2'h0), ea, 2);
      getr(5'h0);
      chk(r, 32'(v));
      setp(p, pa);
      setr(d, ~v);
      exec(cmd(5'h03, d, 3'h0, m, p), 16'h0, 2);
      getr(d);
      chk(r, 32'(v));
      getp(p, ga);
      chk(32'(ga), 32'(na));
    end
    for (int i = 0; i < 4; i++) begin
      p = 2'(1 + i[0]);
      w = i[1] ? 8'h3F : 8'($urandom_range(0, 62));
      pa = 16'($urandom);
      v = 8'($urandom);
      d = 5'($urandom_range(1, 25));
      setp(p, pa);
      setr(d, v);
      exec(cmd(5'h08, d, 3'h0, 2'h0, 2'h0), pa + 16'(w), 2);
      exec(cmd(5'h04, 5'h0, 3'h0, 2'h0, p), 16'(w), 2);
      getr(5'h0);
      chk(r, 32'(v));
      setr(d, ~v);
      exec(cmd(5'h06, d, 3'h0, 2'h0, p), 16'(w), 2);
      exec(cmd(5'h07, 5'h0, 3'h0, 2'h0, 2'h0), pa + 16'(w), 2);
      getr(5'h0);
      chk(r, {24'h00_0000, ~v});
      getp(p, ga);
      chk(32'(ga), 32'(pa));
    end
    v = 8'($urandom);
    apb(1'b1, `CDMB_SP_OFS, 32'h0000_0800);
    setr(5'h03, v);
    exec(cmd(5'h0A, 5'h03, 3'h0, 2'h0, 2'h0), 16'h0, 2);
    apb(1'b0, `CDMB_SP_OFS, 32'h0);
    chk(r, 32'h0000_07FF);
    exec(cmd(5'h0B, 5'h09, 3'h0, 2'h0, 2'h0), 16'h0, 2);
    getr(5'h09);
    chk(r, 32'(v));
    for (int i = 0; i < 3; i++) begin
      pa = 16'($urandom);
      m = (i == 2) ? 2'h3 : 2'(i);
      d = 5'($urandom_range(1, 25));
      setp(2'h2, pa);
      exec(cmd(5'h09, d, 3'h0, m, 2'h2), 16'h0, 3);
      getr((m == 2'h3) ? 5'h0 : d);
      chk(r, 32'(pa[7:0] ^ pa[15:8] ^ 8'hA5));
      getp(2'h2, ga);
      chk(32'(ga), 32'(16'((m == 2'h1) ? pa + 16'h0001 : pa)));
    end
    for (int i = 0; i < 8; i++) begin
      d = 5'($urandom);
      b = 3'($urandom);
      f = i_mem.io_q[d];
      exec(cmd(5'h0C + 5'(i[0]), 5'h0, b, 2'h0, 2'h0), 16'(d), 2);
      @(negedge clk);
      w = i[0] ? f & ~(8'h01 << b) : f | (8'h01 << b);
      chk(32'(i_mem.io_q[d]), 32'(w));
    end
    for (int i = 0; i < 36; i++) begin
      op = 5'h0E + 5'(i % 9);
      v = (i < 9) ? 8'h80 : 8'($urandom);
      f = (i < 9) ? 8'h00 : 8'($urandom);
      b = 3'($urandom);
      d = 5'($urandom);
      setr(d, v);
      apb(1'b1, `CDMB_FLAGS_OFS, {24'h0, f});
      {w, f} = bitop(op, v, f, b);
      exec(cmd(op, d, b, 2'h0, 2'h0), 16'h0, 1);
      getr(d);
      chk(r, 32'(w));
      apb(1'b0, `CDMB_FLAGS_OFS, 32'h0);
      chk(r, 32'(f));
    end
    print_verdict();
  end
endmodule
`default_nettype wire
